// file: src/gof_formatter.sv
// What this block does
// - gyro fields carry selected output unit
// - incremental angle summed since last transmission
// - angle 24-bit two's complement, lsb 2^-21
// - gyro word sent msb, mid, lsb bytes
// - average rate is mean since last send
// - average formed from filtered samples
// - average uses rate encoding and scaling
// - rate 24-bit two's complement, lsb 2^-14
// - integrated angle from reset, wraps silently
// - integrated angle uses incremental encoding
// - temperature 16-bit, high byte then low
// - 8-bit sample counter wraps silently
// - latency 16-bit us, high then low
// - bias trim added after compensation
// - trim writable only in utility/service mode
// - trim in rate lsb added to rate
// - accumulation spans 2000/output-rate samples
module gof_formatter
  import gof_pkg::*;
(
  // clock, enable, reset
  input  wire logic                   ref_clk,
  input  wire logic                   clk_en,
  input  wire logic                   arst_n,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // compensated, filtered samples at 2000 samples/s
  input  wire logic                   smp_valid,
  input  wire logic [gof_pkg::GW-1:0] smp_rate [gof_pkg::NAXIS],
  input  wire logic [gof_pkg::TW-1:0] smp_temp [gof_pkg::NAXIS],
  input  wire logic                   ext_trig,
  input  wire logic [15:0]            trig_latency,
  // byte stream to datagram assembler
  output logic                        byte_valid,
  input  wire logic                   byte_ready,
  output logic [7:0]                  byte_data
);
  // ***********************************************************
  // reset release
  // ***********************************************************
  logic [1:0] rst_sync;  // release synchroniser
  logic       rst_n;     // synchronised reset

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ***********************************************************
  // registers
  // ***********************************************************
  gof_unit_e              unit;                // output unit select
  logic                   cfg_mode;            // utility or service mode active
  logic [7:0]             div;                 // samples per transmission
  logic signed [GW-1:0]   trim [NAXIS];        // bias trim in rate lsb
  logic [7:0]             smp_cnt;             // free counter
  logic [7:0]             n_cnt;               // samples this interval
  logic [15:0]            lat_q;               // latched latency
  logic [7:0]             cnt_cap;             // counter value of the closing sample
  logic                   apb_acc;
  logic                   apb_done;            // access phase answered this cycle
  logic [1:0]             trim_idx;
  logic                   trim_hit;

  assign apb_acc  = psel && penable && !pready;
  // writes commit on the edge at which the master sees pready
  assign apb_done = psel && penable && pready;
  assign trim_hit = (paddr >= ADDR_TRIM0) && (paddr < ADDR_TRIM0 + 8'h0C) && (paddr[1:0] == 2'b00);
  assign trim_idx = 2'((paddr - ADDR_TRIM0) >> 2);

  // apb handshake, one wait state: pready high in the second access cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= apb_acc;
      pslverr <= 1'b0;
      if (apb_acc) begin
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          unique case (1'b1)
            paddr == ADDR_CTRL:    prdata <= {29'h0, cfg_mode, unit};
            paddr == ADDR_DIV:     prdata <= {24'h0, div};
            trim_hit:              prdata <= {{8{trim[trim_idx][GW-1]}}, trim[trim_idx]};
            paddr == ADDR_STATUS:  prdata <= {16'h0, n_cnt, smp_cnt};
            paddr == ADDR_LATENCY: prdata <= {16'h0, lat_q};
            default:               pslverr <= 1'b1;
          endcase
        end else if (!(paddr == ADDR_CTRL || paddr == ADDR_DIV || trim_hit)) begin
          pslverr <= 1'b1;
        end else if (trim_hit && !cfg_mode) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // configuration writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit     <= UNIT_RATE;
      cfg_mode <= 1'b0;
      div      <= DIV_RESET;
    end else if (clk_en && apb_done && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        unit     <= gof_unit_e'(pwdata[CTRL_UNIT_LSB +: 2]);
        cfg_mode <= pwdata[CTRL_MODE_BIT];
      end
      if (paddr == ADDR_DIV && pwdata[7:0] != 8'h00) begin
        div <= pwdata[7:0];
      end
    end
  end

  // trim writes only while in utility or service mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int a = 0; a < NAXIS; a++) trim[a] <= '0;
    end else if (clk_en && apb_done && pwrite && trim_hit && cfg_mode) begin
      trim[trim_idx] <= pwdata[GW-1:0];
    end
  end

  // ***********************************************************
  // sample counting and interval tracking
  // ***********************************************************
  logic       capture;   // last sample of an interval
  logic [1:0] trig_s;    // trigger synchroniser
  logic       trig_d;
  logic       trig_ev;

  // trigger comes from a pin, so it is synchronised first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_s <= 2'b00;
      trig_d <= 1'b0;
    end else if (clk_en) begin
      trig_s <= {trig_s[0], ext_trig};
      trig_d <= trig_s[1];
    end
  end
  assign trig_ev = trig_s[1] && !trig_d;
  // a sample closes the interval when the divider count is reached
  assign capture = smp_valid && (n_cnt + 8'h01 >= div);

  // counters
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt <= 8'h00;
      n_cnt   <= 8'h00;
      lat_q   <= 16'h0000;
      cnt_cap <= 8'h00;
    end else if (clk_en) begin
      // counter frozen with the datagram, so a stalled host cannot skew it
      if (capture) begin
        cnt_cap <= smp_cnt + 8'h01;
      end
      if (smp_valid) begin
        smp_cnt <= smp_cnt + 8'h01;
        n_cnt   <= capture ? 8'h00 : n_cnt + 8'h01;
      end
      if (trig_ev) begin
        lat_q <= trig_latency;
      end
    end
  end

  // ***********************************************************
  // per-axis arithmetic
  // ***********************************************************
  logic signed [GW-1:0]  adj  [NAXIS];   // compensated plus trim
  logic signed [ACC_W-1:0] acc  [NAXIS]; // interval sum, rate lsb
  logic signed [ACC_W-1:0] intg [NAXIS]; // running rate sum, wrapped to the angle span
  // the 24-bit angle span of +-4 deg equals 2000 * 2^17 rate lsb of summed samples
  localparam logic signed [ACC_W-1:0] IMOD  = ACC_W'(ANG_DIV * 131072);
  localparam logic signed [ACC_W-1:0] IHALF = ACC_W'(ANG_DIV * 65536);
  logic signed [GW-1:0]  word [NAXIS];   // captured gyro word
  logic [TW-1:0]         tcap [NAXIS];   // captured temperature

  for (genvar a = 0; a < NAXIS; a++) begin : g_axis
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W+8-1:0] scaled;
    logic signed [ACC_W+8-1:0] iscaled;
    logic signed [ACC_W-1:0] isum;
    logic signed [ACC_W-1:0] inext;

    assign adj[a]  = GW'($signed(smp_rate[a]) + trim[a]);
    assign sum     = acc[a] + ACC_W'(adj[a]);
    // sum of rate lsb 2^-14 times 1/2000 s into lsb 2^-21
    assign scaled  = ((ACC_W+8)'(sum) * (ACC_W+8)'(ANG_MUL)) / (ACC_W+8)'(ANG_DIV);
    // one step back into range is enough: a sample moves the sum far less than half the span
    assign isum    = intg[a] + ACC_W'(adj[a]);
    assign inext   = (isum >= IHALF) ? isum - IMOD : ((isum < -IHALF) ? isum + IMOD : isum);
    assign iscaled = ((ACC_W+8)'(inext) * (ACC_W+8)'(ANG_MUL)) / (ACC_W+8)'(ANG_DIV);

    // interval accumulators restart at each capture so no sample counts twice
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        acc[a]  <= '0;
        intg[a] <= '0;
        word[a] <= '0;
        tcap[a] <= '0;
      end else if (clk_en && smp_valid) begin
        acc[a]  <= capture ? '0 : sum;
        // integrated angle wraps into the +-4 deg span silently
        intg[a] <= inext;
        if (capture) begin
          tcap[a] <= smp_temp[a];
          unique case (unit)
            UNIT_RATE: word[a] <= adj[a];
            UNIT_INCR: word[a] <= GW'(scaled);
            // divisor kept signed so a negative sum divides toward zero
            UNIT_AVG:  word[a] <= GW'(sum / $signed(ACC_W'(div)));
            UNIT_INTG: word[a] <= GW'(iscaled);
          endcase
        end
      end
    end
  end

  // ***********************************************************
  // serialiser: per axis 3 gyro bytes, 2 temp bytes, then counter, latency
  // ***********************************************************
  localparam logic [4:0] NBYTES = 5'd18;  // 3*5 + 1 + 2
  logic [4:0] bidx;       // byte index while sending
  logic       busy;
  logic [7:0] cur;
  logic       in_ready;
  logic       sk_valid;
  logic [7:0] sk_data;
  logic [1:0] ax;
  logic [2:0] sub;

  assign ax  = (bidx < 5'd15) ? 2'(bidx / 5'd5) : 2'h0;
  assign sub = 3'(bidx % 5'd5);

  always_comb begin
    cur = 8'h00;
    if (bidx < 5'd15) begin
      unique case (sub)
        3'h0:    cur = word[ax][23:16];
        3'h1:    cur = word[ax][15:8];
        3'h2:    cur = word[ax][7:0];
        3'h3:    cur = tcap[ax][15:8];
        default: cur = tcap[ax][7:0];
      endcase
    end else if (bidx == 5'd15) begin
      cur = cnt_cap;
    end else if (bidx == 5'd16) begin
      cur = lat_q[15:8];
    end else begin
      cur = lat_q[7:0];
    end
  end

  // step through bytes while the buffer accepts them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      bidx <= 5'd0;
    end else if (clk_en) begin
      if (!busy && smp_valid && capture) begin
        busy <= 1'b1;
        bidx <= 5'd0;
      end else if (busy && in_ready) begin
        busy <= (bidx != NBYTES - 5'd1);
        bidx <= bidx + 5'd1;
      end
    end
  end

  gof_skid #(.W(8)) u_buf (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .ce        (clk_en),
    .in_valid  (busy),
    .in_ready  (in_ready),
    .in_data   (cur),
    .out_valid (sk_valid),
    .out_ready (byte_ready && !byte_valid),
    .out_data  (sk_data)
  );

  // output register, holds until the assembler takes it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end else if (clk_en) begin
      if (byte_valid && byte_ready) begin
        byte_valid <= 1'b0;
      end else if (!byte_valid && sk_valid && byte_ready) begin
        byte_valid <= 1'b1;
        byte_data  <= sk_data;
      end
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  a_trim_locked : assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !cfg_mode |=> $stable(trim[0])) else $error("trim changed outside mode");
  a_cnt_step : assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && smp_valid |=> smp_cnt == 8'($past(smp_cnt) + 8'h01)) else $error("counter step");
  a_acc_clear : assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && capture |=> acc[0] == '0) else $error("accumulator not cleared");
  a_rate_word : assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && capture && unit == UNIT_RATE |=> word[0] == $past(adj[0])) else $error("rate word");
  a_interval_len : assert property (@(posedge ref_clk) disable iff (!rst_n)
    n_cnt < div || div == 8'h00) else $error("interval overrun");
  a_temp_cap : assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && capture |=> tcap[1] == $past(smp_temp[1])) else $error("temperature capture");
  a_lat_cap : assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && trig_ev |=> lat_q == $past(trig_latency)) else $error("latency capture");
  a_apb_ready : assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && psel && penable && !pready |=> pready) else $error("apb answer late");
endmodule : gof_formatter

// file: src/gof_pkg.sv
package gof_pkg;
  // ***********************************************************
  // register map (apb byte addresses)
  // ***********************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;  // output unit, utility/service mode enable
  localparam logic [7:0] ADDR_DIV      = 8'h04;  // internal samples per transmission
  localparam logic [7:0] ADDR_TRIM0    = 8'h08;  // bias trim axis 0, +4 per axis
  localparam logic [7:0] ADDR_STATUS   = 8'h14;  // counter and sample count
  localparam logic [7:0] ADDR_LATENCY  = 8'h18;  // external trigger latency in us
  // ***********************************************************
  // field layout and reset values
  // ***********************************************************
  localparam int         CTRL_UNIT_LSB = 0;      // two bits of output unit
  localparam int         CTRL_MODE_BIT = 2;      // trim write enable (utility/service mode)
  localparam logic [7:0] DIV_RESET     = 8'h08;  // 2000 / 250 samples/s
  localparam int         INT_RATE_SPS  = 2000;   // internal sample rate
  localparam int         NAXIS         = 3;
  localparam int         GW            = 24;     // gyro word width
  localparam int         TW            = 16;     // temperature width
  localparam int         ACC_W         = 32;     // accumulator width
  // rate lsb 2^-14, angle lsb 2^-21: angle = sum(rate)/2000 -> scale 2^7/2000
  localparam int         ANG_MUL       = 128;
  localparam int         ANG_DIV       = INT_RATE_SPS;
  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [1:0] {
    UNIT_RATE = 2'b00,
    UNIT_INCR = 2'b01,
    UNIT_AVG  = 2'b10,
    UNIT_INTG = 2'b11
  } gof_unit_e;
endpackage : gof_pkg

// file: src/gof_skid.sv
// two-entry buffer with valid/ready on both sides
module gof_skid
  import gof_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem [2];  // storage, indexed
  logic         wp;       // write index
  logic         rp;       // read index
  logic [1:0]   cnt;      // entries held
  logic         push;
  logic         pop;

  assign push      = in_valid && (cnt != 2'h2);
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];

  // storage and pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (ce) begin
      if (push) begin
        mem[wp] <= in_data;
        wp      <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  a_no_overflow : assert property (@(posedge clk) disable iff (!rst_n)
    !in_ready |=> $stable(mem[0]) && $stable(mem[1])) else $error("full buffer overwritten");
endmodule : gof_skid

// file: test/gof_host_model.sv
// byte sink standing in for the datagram assembler and host link
module gof_host_model (
  // clock and pacing
  input  wire logic       clk,
  input  wire logic       slow,
  // byte stream from the formatter
  input  wire logic       byte_valid,
  output logic            byte_ready,
  input  wire logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // bytes received, oldest first; four-state so unknowns reach the compare
  logic [7:0] rx_q [$];
  initial byte_ready = 1'b0;
  // take a byte when both sides agree; stall at random when slow
  always @(posedge clk) begin
    if (byte_valid && byte_ready) begin
      rx_q.push_back(byte_data);
    end
    byte_ready <= slow ? 1'($urandom % 2) : 1'b1;
  end
endmodule : gof_host_model

// file: test/gyro_output_formatter_tb.sv
module gyro_output_formatter_tb;
  import gof_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // signals and model state
  // ****
  localparam longint MOD = 2000 * 2**17;  // integrated wrap span in rate lsb
  logic          ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr, byte_data;
  logic [31:0]   pwdata, prdata, rd;
  logic          smp_valid, ext_trig, byte_valid, byte_ready, slow, err, pos;
  logic [GW-1:0] smp_rate [NAXIS];
  logic [TW-1:0] smp_temp [NAXIS];
  logic [15:0]   trig_latency, lat;
  logic [1:0]    unit;
  logic [7:0]    exp_q [$];
  longint        acc [NAXIS], intg [NAXIS], trim [NAXIS];
  int            n_errors, tests_run, cnt, icnt, div;
  // ****
  // design and far side
  // ****
  gof_formatter u_gof_formatter (.ref_clk(ref_clk), .clk_en(1'b1), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .smp_valid(smp_valid),
    .smp_rate(smp_rate), .smp_temp(smp_temp), .ext_trig(ext_trig),
    .trig_latency(trig_latency), .byte_valid(byte_valid), .byte_ready(byte_ready),
    .byte_data(byte_data));
  gof_host_model u_gof_host_model (.clk(ref_clk), .slow(slow), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .byte_data(byte_data));
  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ****
  // helpers
  // ****
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic timeout();
    n_errors++;
    $display("mismatch wait expected answer seen timeout");
    final_report();
  endtask : timeout
  // angle wraps into [-4, 4) degrees, silently
  function automatic longint wrapi(longint x);
    x = x % MOD;
    if (x >= MOD / 2) x -= MOD;
    if (x < -MOD / 2) x += MOD;
    return x;
  endfunction : wrapi
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50) timeout();
    @(posedge ref_clk);
  endtask : apb
  // one internal sample; the model predicts the datagram it closes
  task automatic sample();
    int r;
    longint v, g;
    logic [15:0] t;
    logic cap;
    cap = (icnt + 1 == div);
    for (int a = 0; a < NAXIS; a++) begin
      r = $urandom_range(0, 8388607) - 4194304;
      if (pos) r = $urandom_range(4000000, 4194303);       // corner: steady turn wraps the angle
      t = 16'($urandom);
      smp_rate[a] <= GW'(r);
      smp_temp[a] <= t;
      v = r + trim[a];
      acc[a] += v;
      intg[a] = wrapi(intg[a] + v);
      case (unit)
        2'd0: g = v;
        2'd1: g = acc[a] * ANG_MUL / ANG_DIV;
        2'd2: g = acc[a] / div;
        default: g = intg[a] * ANG_MUL / ANG_DIV;
      endcase
      if (cap) begin
        exp_q.push_back(8'(g >> 16));
        exp_q.push_back(8'(g >> 8));
        exp_q.push_back(8'(g));
        exp_q.push_back(t[15:8]);
        exp_q.push_back(t[7:0]);
        acc[a] = 0;
      end
    end
    if (cap) begin
      exp_q.push_back(8'(cnt + 1));
      exp_q.push_back(lat[15:8]);
      exp_q.push_back(lat[7:0]);
    end
    smp_valid <= 1'b1;
    @(posedge ref_clk);
    smp_valid <= 1'b0;
    cnt++;
    icnt = cap ? 0 : icnt + 1;
    repeat (40) @(posedge ref_clk);
  endtask : sample
  // n whole intervals of d samples in unit u, then compare the stream
  task automatic run(logic [1:0] u, int d, int n);
    int i;
    logic [7:0] b;
    apb(1'b1, ADDR_CTRL, {30'h0, u});
    unit = u;
    apb(1'b1, ADDR_DIV, 32'(d));
    div = d;
    trig_latency <= 16'($urandom);
    ext_trig <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ext_trig <= 1'b0;
    lat = trig_latency;
    repeat (6) @(posedge ref_clk);
    apb(1'b0, ADDR_LATENCY, 32'h0);
    check("latency reg", rd, {16'h0, lat});
    repeat (n * d) sample();
    for (i = 0; i < 3000 && u_gof_host_model.rx_q.size() < exp_q.size(); i++) @(posedge ref_clk);
    if (i == 3000) timeout();
    for (i = 0; exp_q.size() > 0; i++) begin
      b = u_gof_host_model.rx_q.pop_front();
      check("datagram byte", b, exp_q.pop_front());
    end
    check("extra bytes", u_gof_host_model.rx_q.size(), 0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status", {16'h0, rd[15:0]}, {16'h0, 8'(icnt), 8'(cnt)});
    $display("test unit %0d div %0d done", u, d);
  endtask : run
  // ****
  // main sequence
  // ****
  initial begin
    {arst_n, psel, penable, pwrite, smp_valid, ext_trig, slow, pos} = '0;
    {paddr, pwdata, trig_latency, lat, unit} = '0;
    {n_errors, tests_run, cnt, icnt} = '0;
    div = 8;
    for (int a = 0; a < NAXIS; a++) begin
      {smp_rate[a], smp_temp[a], acc[a], intg[a], trim[a]} = '0;
    end
    void'($urandom(32'h4451));
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // reset values, refused accesses, ignored zero divider
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b1, ADDR_DIV, 32'h0);
    apb(1'b0, ADDR_DIV, 32'h0);
    check("div reset", rd, {24'h0, DIV_RESET});
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    apb(1'b1, ADDR_TRIM0, 32'h123);
    check("trim lock err", 32'(err), 32'h1);
    apb(1'b0, ADDR_TRIM0, 32'h0);
    check("trim locked", rd, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h4);
    for (int a = 0; a < NAXIS; a++) begin
      trim[a] = int'($urandom_range(0, 2000)) - 1000;
      apb(1'b1, 8'(ADDR_TRIM0 + 4 * a), 32'(trim[a]));
      check("trim write err", 32'(err), 32'h0);
      apb(1'b0, 8'(ADDR_TRIM0 + 4 * a), 32'h0);
      check("trim value", rd, 32'(trim[a]));
    end
    $display("test registers done");
    // every unit at default and short interval, host stalling on odd units
    for (int u = 0; u < 4; u++) begin
      slow = u[0];
      run(2'(u), 8, 2);
      run(2'(u), 3, 2);
    end
    // long run wraps the sample counter past 255 and the integrated angle
    slow = 1'b1;
    pos = 1'b1;
    run(2'd3, 8, 25);
    final_report();
  end
endmodule : gyro_output_formatter_tb
